// ===== rtl/tuning_updown_decade_counter.sv
// Purpose: Six-decade tuning word counter with 0-2 top stage, encoder, remote load and display scan.
// Assumes: All pin inputs are asynchronous to mclk; encoder clock is sampled, not a clock.
// Notes:   A 16-word FIFO logs each counted word for software when logging is on.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic                     ce,
    input  wire logic                     inValid,
    output logic                          inReady,
    input  wire logic [WIDTH-1:0]         inData,
    output logic                          outValid,
    input  wire logic                     outReady,
    output logic [WIDTH-1:0]              outData,
    output logic [$clog2(DEPTH):0]        fill
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      fill_r;
    wire              doPush;
    wire              doPop;

    assign inReady  = (fill_r != (AW+1)'(DEPTH));
    assign outValid = (fill_r != '0);
    assign outData  = mem[rdPtr_r];
    assign fill     = fill_r;
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_ff @(posedge mclk) begin
        if (ce && doPush) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            fill_r  <= '0;
        end else if (ce) begin
            wrPtr_r <= doPush ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
            rdPtr_r <= doPop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
            fill_r  <= (AW+1)'(fill_r + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop});
        end
    end
endmodule

// What this block does
// - Stage counts up when direction high, else down
// - Parallel load copies presets, ignoring clock
// - High carry-in blocks a stage from counting
// - Carry-out low at 9 up, 0 down
// - Carry-in fed from previous carry-out; shared controls
// - Top stage wraps 0,1,2 up; reverse down
// - Remote load sets all decade and top bits; else ignored
// - Step lines active low, unchosen read high
// - Coarser step freezes lowest one to three decades
// - Clock and direction inverted alike, phase kept
// - Load pulse transfers presets; counting resumes after
// - Free 3-bit scan counter near 2.3 kHz
// - Selector routes input N when select equals N
// - Scan 000 shows least significant digit
// - Scan count also driven to display board
// - Power fail raises step common, inhibits decades
module tuning_updown_decade_counter
    import tuning_pkg::*;
#(
    parameter int SCAN_DIV = SCAN_DIV_DEF
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              encClkPin,
    input  wire logic              encDirPin,
    input  wire logic              remoteLoad,
    input  wire freqWord_t         remotePreset,
    input  wire logic [3:0]        stepSel_b,
    input  wire logic              powerFail,
    output logic                   stepCommon,
    output freqWord_t              synthWord,
    output dispBus_t               display
);
    // Two-flop synchroniser for every pin input
    logic [SYNC_W-1:0]    meta_r;
    logic [SYNC_W-1:0]    sync_r;
    logic                 clkPrev_r;
    freqWord_t            word_r;
    logic [31:0]          ctrl_r;
    logic                 pready_r;
    logic [31:0]          prdata_r;
    logic                 pslverr_r;
    logic [SCAN_DIV_W-1:0] div_r;
    logic [2:0]           scan_r;
    logic [3:0]           dispData_r;
    logic                 stepCommon_r;
    freqWord_t            synth_r;

    wire                  encClk;
    wire                  encDir;
    wire                  loadSync;
    freqWord_t            presetSync;
    wire [3:0]            stepSync_b;
    wire                  pfSync;
    wire [3:0]            chosen;
    wire                  anyChosen;
    wire [1:0]            freeze;
    wire [NUM_DEC:0]      carryIn;
    wire [NUM_DEC:0]      carryOut_b;
    wire [NUM_DEC:0]      terminal;
    wire                  countEdge;
    wire                  stepEn;
    wire                  logOn;
    wire                  fifoReady;
    wire                  fifoValid;
    wire [WORD_W-1:0]     fifoData;
    wire [4:0]            fifoFill;
    freqWord_t            wordNxt;
    wire                  apbAccess;
    wire                  apbDone;
    wire                  addrOk;
    wire [31:0]           rdData;
    wire                  logPop;
    wire                  scanTick;
    wire [3:0]            scanDigit;

    function automatic logic [3:0] decStep(input logic [3:0] d, input logic up);
        if (up) begin
            decStep = (d >= DEC_MAX) ? DEC_MIN : 4'(d + 4'h1);
        end else begin
            decStep = (d == DEC_MIN) ? DEC_MAX : 4'(d - 4'h1);
        end
    endfunction

    function automatic logic [1:0] topStep(input logic [1:0] t, input logic up);
        if (up) begin
            topStep = (t >= TOP_MAX) ? TOP_MIN : 2'(t + 2'h1);
        end else begin
            topStep = (t == TOP_MIN) ? TOP_MAX : 2'(t - 2'h1);
        end
    endfunction

    // Both encoder lines are inverted alike so their phase relation holds
    assign encClk     = ~sync_r[0];
    assign encDir     = ~sync_r[1];
    assign loadSync   = sync_r[2];
    assign presetSync = sync_r[28:3];
    assign stepSync_b = sync_r[32:29];
    // Power fail has its own two-flop pair; only the second flop is read
    logic  pfMeta_r;
    logic  pfReg_r;
    assign pfSync     = pfReg_r;

    // A line counts as chosen only when driven low and the common is low
    assign chosen     = ~stepSync_b & {4{~pfSync}};
    assign anyChosen  = |chosen;
    assign freeze     = chosen[0] ? 2'd0 : chosen[1] ? 2'd1 :
                        chosen[2] ? 2'd2 : 2'd3;

    assign carryIn[0] = !(anyChosen && (freeze == 2'd0));
    genvar i;
    generate
        for (i = 1; i <= NUM_DEC; i++) begin : gChain
            assign carryIn[i] = !anyChosen || (3'(i) < {1'b0, freeze}) ||
                                ((3'(i) > {1'b0, freeze}) && carryOut_b[i-1]);
        end
        for (i = 0; i < NUM_DEC; i++) begin : gDec
            assign terminal[i] = encDir ? (word_r.dec[i] == DEC_MAX)
                                        : (word_r.dec[i] == DEC_MIN);
            assign wordNxt.dec[i] = loadSync ? presetSync.dec[i] :
                (stepEn && !carryIn[i]) ? decStep(word_r.dec[i], encDir)
                                        : word_r.dec[i];
        end
    endgenerate
    assign terminal[NUM_DEC] = encDir ? (word_r.top == TOP_MAX) : (word_r.top == TOP_MIN);
    assign carryOut_b        = carryIn | ~terminal;
    assign wordNxt.top       = loadSync ? presetSync.top :
        (stepEn && !carryIn[NUM_DEC]) ? topStep(word_r.top, encDir)
                                      : word_r.top;

    // Direction is sampled only at the rising edge of the counting clock
    assign countEdge = encClk && !clkPrev_r;
    assign logOn     = ctrl_r[CTRL_LOG_BIT];
    // A full log stalls counting so no logged step is lost
    assign stepEn    = countEdge && !loadSync && (!logOn || fifoReady);

    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) uLog (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .inValid  (stepEn && logOn),
        .inReady  (fifoReady),
        .inData   (wordNxt),
        .outValid (fifoValid),
        .outReady (logPop),
        .outData  (fifoData),
        .fill     (fifoFill)
    );

    // APB slave: one wait state, answer registered
    assign apbAccess = psel && penable && !pready_r;
    assign apbDone   = psel && penable && pready_r;
    assign addrOk    = (paddr == OFS_CTRL) || (paddr == OFS_WORD) ||
                       (paddr == OFS_STATUS) || (paddr == OFS_LOG);
    assign rdData    = (paddr == OFS_CTRL)   ? ctrl_r :
                       (paddr == OFS_WORD)   ? {6'h00, word_r} :
                       (paddr == OFS_STATUS) ? {19'h0, loadSync, stepSync_b, pfSync,
                                                !fifoReady, !fifoValid, fifoFill} :
                       (paddr == OFS_LOG)    ? {6'h00, fifoValid ? fifoData : 26'h0} :
                                               32'h0000_0000;
    assign logPop    = apbDone && !pwrite && (paddr == OFS_LOG) && fifoValid;

    // Scan divider and digit selector
    assign scanTick  = (div_r == SCAN_DIV_W'(SCAN_DIV - 1));
    assign scanDigit = (scan_r == 3'd6) ? {2'b00, word_r.top} :
                       (scan_r == 3'd7) ? 4'h0 : word_r.dec[scan_r];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r    <= '0;
            sync_r    <= '0;
            pfMeta_r  <= 1'b0;
            pfReg_r   <= 1'b0;
            // Synchronised pin idles low, so the inverted clock idles high;
            // matching it here keeps a false count edge out of reset release
            clkPrev_r <= 1'b1;
        end else if (ce) begin
            meta_r    <= {stepSel_b, remotePreset, remoteLoad, encDirPin, encClkPin};
            sync_r    <= meta_r;
            pfMeta_r  <= powerFail;
            pfReg_r   <= pfMeta_r;
            clkPrev_r <= encClk;
        end
    end

    // No documented reset on the word; zero keeps simulation defined
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            word_r  <= '0;
            synth_r <= '0;
        end else if (ce) begin
            word_r  <= wordNxt;
            synth_r <= wordNxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r    <= CTRL_RST;
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= apbAccess;
            prdata_r  <= (apbAccess && !pwrite) ? rdData : 32'h0000_0000;
            pslverr_r <= apbAccess && !addrOk;
            if (apbDone && pwrite && (paddr == OFS_CTRL)) begin
                ctrl_r <= {31'h0, pwdata[CTRL_LOG_BIT]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_r        <= '0;
            scan_r       <= 3'd0;
            dispData_r   <= 4'h0;
            stepCommon_r <= 1'b0;
        end else if (ce) begin
            div_r        <= scanTick ? '0 : SCAN_DIV_W'(div_r + 1'b1);
            scan_r       <= scanTick ? 3'(scan_r + 3'd1) : scan_r;
            dispData_r   <= scanDigit;
            stepCommon_r <= pfSync;
        end
    end

    assign pready       = pready_r;
    assign prdata       = prdata_r;
    assign pslverr      = pslverr_r;
    assign stepCommon   = stepCommon_r;
    assign synthWord    = synth_r;
    assign display.scan = scan_r;
    assign display.data = dispData_r;
endmodule

// ===== rtl/tuning_pkg.sv
// Purpose: Shared constants and types of the tuning up/down decade counter.
// Assumes: 20 MHz system clock, APB register access.
// Notes:   Every register offset, the control reset value and the scan timing count are named once here.
package tuning_pkg;

    localparam int          CLK_HZ       = 20_000_000;
    localparam int          SCAN_HZ      = 2300;
    localparam int          SCAN_DIV_DEF = CLK_HZ / SCAN_HZ;
    localparam int          SCAN_DIV_W   = 16;

    localparam int          NUM_DEC      = 6;
    localparam int          DIGIT_W      = 4;
    localparam int          WORD_W       = 26;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          SYNC_W       = 33;

    localparam logic [3:0]  DEC_MAX      = 4'h9;
    localparam logic [3:0]  DEC_MIN      = 4'h0;
    localparam logic [1:0]  TOP_MAX      = 2'h2;
    localparam logic [1:0]  TOP_MIN      = 2'h0;

    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_WORD     = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_LOG      = 8'h0c;

    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam int          CTRL_LOG_BIT = 0;

    localparam int          ST_CNT_LSB   = 0;
    localparam int          ST_EMPTY_BIT = 5;
    localparam int          ST_FULL_BIT  = 6;
    localparam int          ST_PF_BIT    = 7;
    localparam int          ST_STEP_LSB  = 8;
    localparam int          ST_LOAD_BIT  = 12;

    typedef struct packed {
        logic [1:0]                    top;
        logic [NUM_DEC-1:0][DIGIT_W-1:0] dec;
    } freqWord_t;

    typedef struct packed {
        logic [2:0] scan;
        logic [3:0] data;
    } dispBus_t;

endpackage

// ===== tb/remote_tuner_model.sv
// Purpose: Quadrature knob encoder and remote preset controller.
// Assumes: 400 ns encoder cycle; encoder clock idle low between detents.
// Notes:   Preset lines carry the inverse word once a load is over.
`timescale 1ns/1ps

module remote_tuner_model
    import tuning_pkg::*;
(
    input  wire logic mclk,
    output logic      encClkPin,
    output logic      encDirPin,
    output logic      remoteLoad,
    output freqWord_t remotePreset
);
    initial begin
        encClkPin = 1'b0;
        encDirPin = 1'b0;
        remoteLoad = 1'b0;
        remotePreset = '0;
    end

    task automatic quarter(input logic [1:0] cd);
        repeat (2) @(posedge mclk);
        encClkPin <= cd[1];
        encDirPin <= cd[0];
    endtask

    // Up: direction leads the clock; down: the clock leads
    task automatic turn(input logic up);
        quarter(up ? 2'b01 : 2'b10);
        quarter(2'b11);
        quarter(up ? 2'b10 : 2'b01);
        quarter(2'b00);
        repeat (6) @(posedge mclk);
    endtask

    task automatic load(input freqWord_t w);
        remotePreset <= w;
        repeat (2) @(posedge mclk);
        remoteLoad <= 1'b1;
        repeat (4) @(posedge mclk);
        remoteLoad <= 1'b0;
        repeat (4) @(posedge mclk);
        remotePreset <= ~w;
        repeat (4) @(posedge mclk);
    endtask
endmodule

// ===== tb/tuning_counter_chk.sv
// Purpose: Port assertions for the tuning decade counter.
// Assumes: ce held high.
// Notes:   Bound to every instance of the counter.
`timescale 1ns/1ps

module tuning_counter_chk
    import tuning_pkg::*;
#(
    parameter int SCAN_DIV = 8
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        encClkPin,
    input wire logic        remoteLoad,
    input wire logic        powerFail,
    input wire logic        stepCommon,
    input wire freqWord_t   synthWord,
    input wire dispBus_t    display
);
    logic        encPrev_r;
    logic [3:0]  quiet_r;
    logic [2:0]  scanPrev_r;
    logic [15:0] hold_r;
    logic        seen_r;
    wire         scanChg = display.scan != scanPrev_r;
    wire         encFall = encPrev_r && !encClkPin;
    wire  [3:0]  digSel = (display.scan == 3'h7) ? 4'h0 :
                          (display.scan == 3'h6) ? {2'h0, synthWord.top} :
                          synthWord.dec[display.scan];

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Cycles since the last encoder fall or load, saturating
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            encPrev_r <= 1'b0;
            quiet_r <= 4'h0;
            scanPrev_r <= 3'h0;
            hold_r <= 16'h0;
            seen_r <= 1'b0;
        end else begin
            encPrev_r <= encClkPin;
            quiet_r <= (encFall || remoteLoad) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
            scanPrev_r <= display.scan;
            hold_r <= scanChg ? 16'h0 : hold_r + 16'h1;
            seen_r <= seen_r || scanChg;
        end
    end

    apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready timing wrong");
    slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    word_cause_a: assert property ($changed(synthWord) |-> quiet_r < 4'h6)
        else $error("word changed without cause");
    scan_period_a: assert property (seen_r |-> scanChg == (hold_r == 16'(SCAN_DIV - 1)))
        else $error("scan period wrong");
    scan_order_a: assert property (scanChg |-> display.scan == scanPrev_r + 3'h1)
        else $error("scan order wrong");
    digit_route_a: assert property (display.data == $past(digSel))
        else $error("display digit wrong");
    pf_raise_a: assert property ($rose(powerFail) |-> ##[1:4] stepCommon)
        else $error("step common not raised");
    pf_drop_a: assert property ($fell(powerFail) |-> ##[1:4] !stepCommon)
        else $error("step common not dropped");

    cover property (pslverr);
    cover property (stepCommon);
    cover property (scanChg && display.scan == 3'h0);
endmodule

bind tuning_updown_decade_counter tuning_counter_chk #(.SCAN_DIV(SCAN_DIV)) i_tuning_counter_chk (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .encClkPin(encClkPin), .remoteLoad(remoteLoad),
    .powerFail(powerFail), .stepCommon(stepCommon), .synthWord(synthWord), .display(display)
);

// ===== tb/tuning_updown_decade_counter_tb.sv
// Purpose: Self-checking bench for the tuning decade counter.
// Assumes: SCAN_DIV cut to 8; ce held high.
// Notes:   The expected word is an integer modulo 3000000.
`timescale 1ns/1ps

module tuning_updown_decade_counter_tb
    import tuning_pkg::*;
;
    localparam int SCAN_DIV = 8;
    localparam int LIMIT    = 20000;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  stepSel_b = 4'he;
    logic        powerFail = 1'b0;
    logic        pready, pslverr, stepCommon, encClkPin, encDirPin, remoteLoad, e;
    logic [31:0] prdata, q;
    freqWord_t   remotePreset, synthWord;
    dispBus_t    display;
    int          v, failCount, checkCount, cycles;
    int          logQ[$];

    initial forever #25 mclk = ~mclk;

    remote_tuner_model i_remote_tuner_model (.mclk(mclk), .encClkPin(encClkPin),
        .encDirPin(encDirPin), .remoteLoad(remoteLoad), .remotePreset(remotePreset));

    tuning_updown_decade_counter #(.SCAN_DIV(SCAN_DIV)) i_tuning_updown_decade_counter (
        .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .encClkPin(encClkPin), .encDirPin(encDirPin),
        .remoteLoad(remoteLoad), .remotePreset(remotePreset), .stepSel_b(stepSel_b),
        .powerFail(powerFail), .stepCommon(stepCommon), .synthWord(synthWord),
        .display(display));

    task automatic check(input string what, input logic [31:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic freqWord_t toWord(input int x);
        freqWord_t w;
        for (int i = 0; i < NUM_DEC; i++) begin
            w.dec[i] = 4'(x % 10);
            x = x / 10;
        end
        w.top = 2'(x);
        return w;
    endfunction

    function automatic logic [3:0] digit(input int x, input int n);
        freqWord_t w;
        w = toWord(x);
        return n < 6 ? w.dec[n] : (n == 6 ? {2'h0, w.top} : 4'h0);
    endfunction

    task automatic stepChk(input logic up, input int k);
        i_remote_tuner_model.turn(up);
        v = (v + (up ? 10 ** k : 3000000 - 10 ** k)) % 3000000;
        check("word", 32'(synthWord), 32'(toWord(v)));
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failCount++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        check("word", 32'(synthWord), 32'h0);
        check("stepCommon", 32'(stepCommon), 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl", q, CTRL_RST);
        apb(1'b0, 8'h10, 32'h0);
        check("slverr", 32'(e), 32'h1);
        check("rdata", q, 32'h0);
        v = 2999999;
        i_remote_tuner_model.load(toWord(v));
        check("load", 32'(synthWord), 32'(toWord(v)));
        stepChk(1'b1, 0);
        stepChk(1'b0, 0);
        for (int k = 0; k < 4; k++) begin
            stepSel_b <= ~(4'h1 << k);
            stepChk(1'b1, k);
            stepChk(1'b0, k);
        end
        stepSel_b <= 4'hf;
        i_remote_tuner_model.turn(1'b1);
        check("frozen", 32'(synthWord), 32'(toWord(v)));
        stepSel_b <= 4'he;
        powerFail <= 1'b1;
        repeat (6) @(posedge mclk);
        check("stepCommon", 32'(stepCommon), 32'h1);
        i_remote_tuner_model.turn(1'b1);
        check("inhibit", 32'(synthWord), 32'(toWord(v)));
        powerFail <= 1'b0;
        repeat (6) @(posedge mclk);
        check("stepCommon", 32'(stepCommon), 32'h0);
        stepChk(1'b1, 0);
        v = 1234567;
        i_remote_tuner_model.load(toWord(v));
        for (int n = 0; n < 8; n++) begin
            while (display.scan !== 3'(n)) @(posedge mclk);
            repeat (2) @(posedge mclk);
            check("display", 32'(display.data), 32'(digit(v, n)));
        end
        apb(1'b1, OFS_CTRL, 32'h1);
        for (int i = 0; i < 16; i++) begin
            stepChk(1'b1, 0);
            logQ.push_back(v);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status", 32'(q[12:0]), 32'h0e50);
        i_remote_tuner_model.turn(1'b1);
        check("full", 32'(synthWord), 32'(toWord(v)));
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, OFS_LOG, 32'h0);
            check("log", q, 32'(toWord(logQ[i])));
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status", 32'(q[12:0]), 32'h0e20);
        apb(1'b0, OFS_WORD, 32'h0);
        check("wordReg", q, 32'(toWord(v)));
        conclude();
    end
endmodule
